// ### pcwl_pkg.sv
/*
  Package of the port configuration word loader: storage word
  addresses, configuration offsets, field positions, carriers and
  loader states.
  Assumes a three-port switch with 16-bit load words and 12-bit
  configuration offsets.
*/
package pcwl_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_PORTS = 3;
  localparam int WORD_W = 16;
  localparam int WADDR_W = 8;
  localparam int OFF_W = 12;
  localparam int DATA_W = 32;
  localparam int SYNC_FILL = 2;
  localparam logic [1:0] SYNC_FILL_CNT = 2'h2;

  // ****************************************
  // storage word addresses, port 0 first
  // ****************************************
  localparam logic [WADDR_W-1:0] WA_OPTION_P0 = 8'h60;
  localparam logic [WADDR_W-1:0] WA_OPTION_P1 = 8'h62;
  localparam logic [WADDR_W-1:0] WA_OPTION_P2 = 8'h64;
  localparam logic [WADDR_W-1:0] WA_BUDGET_P0 = 8'h70;
  localparam logic [WADDR_W-1:0] WA_BUDGET_P1 = 8'h72;
  localparam logic [WADDR_W-1:0] WA_BUDGET_P2 = 8'h74;
  localparam logic [WADDR_W-1:0] WA_PMCTL_P0 = 8'h80;
  localparam logic [WADDR_W-1:0] WA_PMCTL_P1 = 8'h82;
  localparam logic [WADDR_W-1:0] WA_PMCTL_P2 = 8'h84;
  localparam logic [WADDR_W-1:0] WA_PORT_STEP = 8'h02;

  // ****************************************
  // configuration offsets
  // ****************************************
  localparam logic [OFF_W-1:0] OFF_DSI_PM_CAP = 12'h040;
  localparam logic [OFF_W-1:0] OFF_VGA_DECODE = 12'h070;
  localparam logic [OFF_W-1:0] OFF_PM_CTL_PARAM = 12'h074;
  localparam logic [OFF_W-1:0] OFF_PHY_CTL5 = 12'h088;
  localparam logic [OFF_W-1:0] OFF_EXP_CAP_SLOT = 12'h0c0;
  localparam logic [OFF_W-1:0] OFF_LOGICAL_PORT = 12'h0cc;
  localparam logic [OFF_W-1:0] OFF_SLOT_CLOCK = 12'h0d0;
  localparam logic [OFF_W-1:0] OFF_LOW_PRIORITY_VC_COUNT = 12'h144;
  localparam logic [OFF_W-1:0] OFF_VC0_MAP = 12'h154;
  localparam logic [OFF_W-1:0] OFF_BUDGET_DATA = 12'h214;
  localparam logic [OFF_W-1:0] OFF_BUDGET_ALLOC = 12'h218;

  // ****************************************
  // option word fields and their targets
  // ****************************************
  localparam int OPT_SLOT_IMPL = 0;
  localparam int OPT_CONN_CLK = 1;
  localparam int OPT_DSI = 2;
  localparam int OPT_LPVC = 3;
  localparam int OPT_PNUM_LO = 4;
  localparam int OPT_PNUM_HI = 6;
  localparam int OPT_TCMAP_LO = 9;
  localparam int OPT_TCMAP_HI = 15;
  localparam int REG_SLOT_IMPL = 24;
  localparam int REG_CONN_CLK = 28;
  localparam int REG_DSI = 21;
  localparam int REG_LPVC = 4;
  localparam int REG_PNUM_LO = 24;
  localparam int REG_PNUM_HI = 26;
  localparam int REG_TCMAP_LO = 1;
  localparam int REG_TCMAP_HI = 7;

  // ****************************************
  // power budget word fields and targets
  // ****************************************
  localparam int PB_BASE_LO = 0;
  localparam int PB_BASE_HI = 7;
  localparam int PB_SCALE_LO = 8;
  localparam int PB_SCALE_HI = 9;
  localparam int PB_STATE_LO = 10;
  localparam int PB_STATE_HI = 11;
  localparam int PB_SYS_ALLOC = 15;
  localparam int REG_PB_STATE_LO = 13;
  localparam int REG_PB_STATE_HI = 14;
  localparam int REG_SYS_ALLOC = 0;

  // ****************************************
  // power management control word fields
  // ****************************************
  localparam int PM_PARAM_LO = 0;
  localparam int PM_PARAM_HI = 5;
  localparam int PM_RXPOL_OFF = 6;
  localparam int PM_VGA_EN = 7;
  localparam int PM_PHY_LO = 8;
  localparam int PM_PHY_HI = 15;
  localparam int REG_PM_PARAM_LO = 8;
  localparam int REG_PM_PARAM_HI = 13;
  localparam int REG_RXPOL_OFF = 14;
  localparam int REG_VGA_EN = 31;
  localparam int REG_PHY_LO = 24;
  localparam int REG_PHY_HI = 31;

  // ****************************************
  // reset values and carriers
  // ****************************************
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [WADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } pcwl_word_t;

  typedef struct packed {
    logic [1:0] port;
    logic [OFF_W-1:0] offset;
  } pcwl_cfg_req_t;

  typedef enum logic [2:0] {
    ST_SETTLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_DONE = 3'b100
  } pcwl_state_t;

endpackage

// ### pcwl_loader.sv
/*
  Port configuration word loader: catches 16-bit load words from the
  configuration storage and spreads their fields over the per-port
  configuration registers, which are then read by configuration
  accesses.
  Assumes the storage reader runs on ref_clk_in and marks the end of
  the load with a one-cycle pulse; the presence strap is asynchronous.
*/
// Summary of operation
// - port 1 word bits 15:9 go to port 1 VC0 map bits 7:1
// - port 2 option bit 0 gives slot implemented, C0h bit 24
// - port 2 option bit 1 gives connector clock, D0h bit 28
// - port 2 option bit 2 gives init required, 40h bit 21
// - port 2 option bit 3 gives VC1 low priority, 144h bit 4
// - port 2 option bits 6:4 give logical port number, CCh 26:24
// - port 2 option bits 15:9 give VC0 class map, 154h 7:1
// - budget words 70h, 72h, 74h serve ports 0, 1, 2
// - budget bits 7:0 become base power, 214h bits 7:0
// - budget bits 9:8 become data scale, 214h bits 9:8
// - budget bits 11:10 become power state, 214h bits 14:13
// - budget bit 15 becomes system allocated, 218h bit 0
// - control words 80h, 82h, 84h; low six bits to 74h 13:8
// - control bits 1:0 set entry to L1 from D3
// - control bits 3:2 select delay before L1 entry
// - control bits 5:4 set L0s enable
// - control bit 6 disables receive polarity, 74h bit 14
// - control bit 7 enables VGA decode, 70h bit 31
// - control bits 15:8 go to PHY control top byte, 88h 31:24
module pcwl_loader
  import pcwl_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // storage side
  input wire logic storage_present_in,
  input wire logic word_valid_in,
  input wire pcwl_word_t word_in,
  input wire logic load_end_in,
  // configuration read side
  input wire logic cfg_rd_in,
  input wire pcwl_cfg_req_t cfg_req_in,
  output logic cfg_ack_out,
  output logic [DATA_W-1:0] cfg_rdata_out,
  // status
  output logic load_done_out
);

  // ****************************************
  // storage
  // ****************************************
  logic [WORD_W-1:0] opt_word [NUM_PORTS];
  logic [WORD_W-1:0] pb_word [NUM_PORTS];
  logic [WORD_W-1:0] pm_word [NUM_PORTS];
  logic [3*NUM_PORTS-1:0] seen;
  logic present_meta;
  logic present_sync;
  logic [1:0] settle_cnt;
  pcwl_state_t state;
  logic pend;
  pcwl_cfg_req_t pend_req;
  pcwl_cfg_req_t ack_req;
  pcwl_cfg_req_t sel_req;
  logic loading;
  logic [NUM_PORTS-1:0] take_opt;
  logic [NUM_PORTS-1:0] take_pb;
  logic [NUM_PORTS-1:0] take_pm;

  // ****************************************
  // read view of one register
  // ****************************************
  function automatic logic [DATA_W-1:0] reg_view(
    input logic [1:0] port,
    input logic [OFF_W-1:0] off,
    input logic [WORD_W-1:0] opt,
    input logic [WORD_W-1:0] pb,
    input logic [WORD_W-1:0] pm
  );
    logic [DATA_W-1:0] v;
    v = DATA_RESET;
    case (off)
      OFF_DSI_PM_CAP: v[REG_DSI] = opt[OPT_DSI];
      OFF_VGA_DECODE: v[REG_VGA_EN] = pm[PM_VGA_EN];
      OFF_PM_CTL_PARAM: begin
        v[REG_PM_PARAM_HI:REG_PM_PARAM_LO] = pm[PM_PARAM_HI:PM_PARAM_LO];
        v[REG_RXPOL_OFF] = pm[PM_RXPOL_OFF];
      end
      OFF_PHY_CTL5: v[REG_PHY_HI:REG_PHY_LO] = pm[PM_PHY_HI:PM_PHY_LO];
      // slot implemented, ports 1 and 2
      OFF_EXP_CAP_SLOT: begin
        if (port != 2'h0) begin
          v[REG_SLOT_IMPL] = opt[OPT_SLOT_IMPL];
        end
      end
      OFF_LOGICAL_PORT:
        v[REG_PNUM_HI:REG_PNUM_LO] = opt[OPT_PNUM_HI:OPT_PNUM_LO];
      OFF_SLOT_CLOCK: v[REG_CONN_CLK] = opt[OPT_CONN_CLK];
      OFF_LOW_PRIORITY_VC_COUNT: v[REG_LPVC] = opt[OPT_LPVC];
      OFF_VC0_MAP:
        v[REG_TCMAP_HI:REG_TCMAP_LO] = opt[OPT_TCMAP_HI:OPT_TCMAP_LO];
      OFF_BUDGET_DATA: begin
        v[PB_BASE_HI:PB_BASE_LO] = pb[PB_BASE_HI:PB_BASE_LO];
        v[PB_SCALE_HI:PB_SCALE_LO] = pb[PB_SCALE_HI:PB_SCALE_LO];
        v[REG_PB_STATE_HI:REG_PB_STATE_LO] = pb[PB_STATE_HI:PB_STATE_LO];
      end
      OFF_BUDGET_ALLOC: v[REG_SYS_ALLOC] = pb[PB_SYS_ALLOC];
      default: v = DATA_RESET;
    endcase
    return v;
  endfunction

  // ****************************************
  // presence strap synchroniser
  // ****************************************
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      present_meta <= 1'b0;
      present_sync <= 1'b0;
    end else if (clk_en_in) begin
      present_meta <= storage_present_in;
      present_sync <= present_meta;
    end
  end

  // ****************************************
  // loader sequence
  // ****************************************
  // wait for strap, then load or keep defaults
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_SETTLE;
      settle_cnt <= 2'h0;
      load_done_out <= 1'b0;
    end else if (clk_en_in) begin
      unique case (state)
        ST_SETTLE: begin
          if (settle_cnt == SYNC_FILL_CNT) begin
            state <= present_sync ? ST_LOAD : ST_DONE;
            load_done_out <= !present_sync;
          end else begin
            settle_cnt <= settle_cnt + 2'h1;
          end
        end
        ST_LOAD: begin
          if (load_end_in) begin
            state <= ST_DONE;
            load_done_out <= 1'b1;
          end
        end
        ST_DONE: state <= ST_DONE;
      endcase
    end
  end

  // ****************************************
  // word capture, all ports in one process
  // ****************************************
  assign loading = clk_en_in && state == ST_LOAD && word_valid_in;

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      take_opt[p] = loading && !seen[3*p] &&
        word_in.addr == WA_OPTION_P0 + WADDR_W'(p) * WA_PORT_STEP;
      take_pb[p] = loading && !seen[3*p+1] &&
        word_in.addr == WA_BUDGET_P0 + WADDR_W'(p) * WA_PORT_STEP;
      take_pm[p] = loading && !seen[3*p+2] &&
        word_in.addr == WA_PMCTL_P0 + WADDR_W'(p) * WA_PORT_STEP;
    end
  end

  // first copy of each word wins
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        opt_word[p] <= WORD_RESET;
        pb_word[p] <= WORD_RESET;
        pm_word[p] <= WORD_RESET;
      end
      seen <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (take_opt[p]) begin
          opt_word[p] <= word_in.data;
          seen[3*p] <= 1'b1;
        end
        if (take_pb[p]) begin
          pb_word[p] <= word_in.data;
          seen[3*p+1] <= 1'b1;
        end
        if (take_pm[p]) begin
          pm_word[p] <= word_in.data;
          seen[3*p+2] <= 1'b1;
        end
      end
    end
  end

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_once
    a_word_once: assert property (
      @(posedge ref_clk_in) disable iff (rst_in)
      take_opt[p] |=> !take_opt[p] && opt_word[p] == $past(word_in.data)
    ) else $error("option word taken twice or lost");
  end

  // ****************************************
  // configuration reads
  // ****************************************
  // held request is served before a new one
  assign sel_req = pend ? pend_req : cfg_req_in;

  // first read before load end is held, later ones dropped
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend <= 1'b0;
      pend_req <= '0;
      ack_req <= '0;
      cfg_ack_out <= 1'b0;
      cfg_rdata_out <= DATA_RESET;
    end else if (clk_en_in) begin
      cfg_ack_out <= 1'b0;
      if (state == ST_DONE && (pend || cfg_rd_in)) begin
        pend <= 1'b0;
        cfg_ack_out <= 1'b1;
        ack_req <= sel_req;
        if (sel_req.port < 2'(NUM_PORTS)) begin
          cfg_rdata_out <= reg_view(sel_req.port, sel_req.offset,
            opt_word[sel_req.port], pb_word[sel_req.port],
            pm_word[sel_req.port]);
        end else begin
          cfg_rdata_out <= DATA_RESET;
        end
      end else if (cfg_rd_in && !pend) begin
        pend <= 1'b1;
        pend_req <= cfg_req_in;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_no_early_ack: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out |-> $past(state) == ST_DONE
  ) else $error("read answered before load end");

  a_ack_one_cycle: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    clk_en_in && state == ST_DONE && cfg_rd_in && !pend |=> cfg_ack_out
  ) else $error("read not answered next cycle");

  a_tc_map_p1: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port == 2'h1 && ack_req.offset == OFF_VC0_MAP
    |-> cfg_rdata_out[7:1] == opt_word[1][15:9] && cfg_rdata_out[0] == 1'b0
  ) else $error("port 1 class map wrong");

  a_slot_impl_p2: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port == 2'h2 && ack_req.offset == OFF_EXP_CAP_SLOT
    |-> cfg_rdata_out == {7'h00, opt_word[2][0], 24'h000000}
  ) else $error("slot implemented bit wrong");

  a_port_num_p2: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port == 2'h2 && ack_req.offset == OFF_LOGICAL_PORT
    |-> cfg_rdata_out[26:24] == opt_word[2][6:4]
  ) else $error("logical port number wrong");

  a_budget_data: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port < 2'h3 && ack_req.offset == OFF_BUDGET_DATA
    |-> cfg_rdata_out[14:13] == pb_word[ack_req.port][11:10] &&
        cfg_rdata_out[9:0] == pb_word[ack_req.port][9:0] &&
        cfg_rdata_out[12:10] == 3'h0
  ) else $error("budget data fields wrong");

  a_sys_alloc: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port < 2'h3 && ack_req.offset == OFF_BUDGET_ALLOC
    |-> cfg_rdata_out == {31'h0, pb_word[ack_req.port][15]}
  ) else $error("system allocated bit wrong");

  a_pm_params: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port < 2'h3 && ack_req.offset == OFF_PM_CTL_PARAM
    |-> cfg_rdata_out[14:8] == pm_word[ack_req.port][6:0]
  ) else $error("link power parameters wrong");

  a_phy_byte: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port < 2'h3 && ack_req.offset == OFF_PHY_CTL5
    |-> cfg_rdata_out == {pm_word[ack_req.port][15:8], 24'h000000}
  ) else $error("PHY control byte wrong");

  a_absent_defaults: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    $rose(load_done_out) && $past(state) == ST_SETTLE |-> seen == 9'h000
  ) else $error("words taken without storage");

  a_tc_map_p2: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port == 2'h2 && ack_req.offset == OFF_VC0_MAP
    |-> cfg_rdata_out == {24'h0, opt_word[2][15:9], 1'b0}
  ) else $error("port 2 class map wrong");

  a_conn_clock: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port == 2'h2 && ack_req.offset == OFF_SLOT_CLOCK
    |-> cfg_rdata_out == {3'h0, opt_word[2][1], 28'h0}
  ) else $error("connector clock bit wrong");

  a_init_flag: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port == 2'h2 && ack_req.offset == OFF_DSI_PM_CAP
    |-> cfg_rdata_out == {10'h0, opt_word[2][2], 21'h0}
  ) else $error("init required bit wrong");

  a_lpvc_bit: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port == 2'h2 && ack_req.offset == OFF_LOW_PRIORITY_VC_COUNT
    |-> cfg_rdata_out == {27'h0, opt_word[2][3], 4'h0}
  ) else $error("low priority group bit wrong");

  a_vga_decode: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port < 2'h3 && ack_req.offset == OFF_VGA_DECODE
    |-> cfg_rdata_out == {pm_word[ack_req.port][7], 31'h0}
  ) else $error("VGA decode bit wrong");

  a_base_power: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port < 2'h3 && ack_req.offset == OFF_BUDGET_DATA
    |-> cfg_rdata_out[7:0] == pb_word[ack_req.port][7:0]
  ) else $error("base power wrong");

  a_data_scale: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port < 2'h3 && ack_req.offset == OFF_BUDGET_DATA
    |-> cfg_rdata_out[9:8] == pb_word[ack_req.port][9:8]
  ) else $error("data scale wrong");

  a_l1_entry: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port < 2'h3 && ack_req.offset == OFF_PM_CTL_PARAM
    |-> cfg_rdata_out[9:8] == pm_word[ack_req.port][1:0]
  ) else $error("L1 entry field wrong");

  a_l1_delay: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port < 2'h3 && ack_req.offset == OFF_PM_CTL_PARAM
    |-> cfg_rdata_out[11:10] == pm_word[ack_req.port][3:2]
  ) else $error("L1 delay field wrong");

  a_l0s_enable: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cfg_ack_out && ack_req.port < 2'h3 && ack_req.offset == OFF_PM_CTL_PARAM
    |-> cfg_rdata_out[13:12] == pm_word[ack_req.port][5:4]
  ) else $error("L0s enable field wrong");

  a_freeze_hold: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    !clk_en_in |=> $stable(state) && $stable(cfg_ack_out) &&
      $stable(load_done_out) && $stable(seen)
  ) else $error("state moved while enable low");

endmodule

// ### pcwl_storage_model.sv
/*
  Behavioural model of the configuration storage reader that feeds
  load words to the port configuration word loader.
  Assumes the loader samples on the rising edge of the shared clock
  and that go_in rises only once the loader has left its settle phase.
*/
module pcwl_storage_model
  import pcwl_pkg::*;
(
  // clock and start
  input wire logic clk_in,
  input wire logic go_in,
  // word contents, port 0 first
  input wire logic [2:0][15:0] opt_in,
  input wire logic [2:0][15:0] pb_in,
  input wire logic [2:0][15:0] pm_in,
  // loader side
  output logic valid_out,
  output pcwl_word_t word_out,
  output logic end_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // word delivery
  // ****************************************
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    valid_out = 1'b1;
    word_out = '{addr: a, data: d};
    @(posedge clk_in);
    #1;
  endtask

  initial begin
    valid_out = 1'b0;
    word_out = '0;
    end_out = 1'b0;
    forever begin
      @(posedge go_in);
      @(posedge clk_in);
      #1;
      for (int p = 0; p < 3; p++) begin
        put(WA_PMCTL_P0 + 8'(2 * p), pm_in[p]);
        put(WA_BUDGET_P0 + 8'(2 * p), pb_in[p]);
        put(WA_OPTION_P0 + 8'(2 * p), opt_in[p]);
      end
      put(8'h66, 16'hffff);
      put(WA_OPTION_P2, ~opt_in[2]);
      // released data shows the inverse of the last word
      valid_out = 1'b0;
      word_out = ~word_out;
      end_out = 1'b1;
      @(posedge clk_in);
      #1;
      end_out = 1'b0;
    end
  end
endmodule

// ### port_config_word_loader_bench.sv
/*
  Self-checking bench of the port configuration word loader: loads
  words through the storage model, then reads every mapped field back.
  Assumes the loader answers reads with a one-cycle acknowledge.
*/
module port_config_word_loader_bench
  import pcwl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, rst, clk_en, present, go, cfg_rd, ack, done, w_valid, w_end;
  pcwl_cfg_req_t cfg_req;
  pcwl_word_t w_word;
  logic [31:0] rdata;
  int mismatches = 0;
  int cmp_count = 0;
  logic [2:0][15:0] opt_w = {16'hf37e, 16'ha6c5, 16'h5a3b};
  logic [2:0][15:0] pb_w = {16'hb9f1, 16'h46c9, 16'h8d27};
  logic [2:0][15:0] pm_w = {16'h7eff, 16'hc165, 16'h3c9a};

  pcwl_loader DUT (
    .ref_clk_in(clk), .rst_in(rst), .clk_en_in(clk_en),
    .storage_present_in(present), .word_valid_in(w_valid),
    .word_in(w_word), .load_end_in(w_end), .cfg_rd_in(cfg_rd),
    .cfg_req_in(cfg_req), .cfg_ack_out(ack), .cfg_rdata_out(rdata),
    .load_done_out(done)
  );

  pcwl_storage_model storage (
    .clk_in(clk), .go_in(go), .opt_in(opt_w), .pb_in(pb_w),
    .pm_in(pm_w), .valid_out(w_valid), .word_out(w_word),
    .end_out(w_end)
  );

  always #50 clk = ~clk;

  // ****************************************
  // checking and access tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [1:0] p, input logic [11:0] o,
                    input logic [31:0] e);
    int n;
    @(posedge clk);
    #1;
    cfg_rd = 1'b1;
    cfg_req = '{port: p, offset: o};
    @(posedge clk);
    #1;
    cfg_rd = 1'b0;
    n = 0;
    while (ack !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({31'h0, ack}, 32'h1);
    check(rdata, e);
  endtask

  task automatic check_port(input logic [1:0] p, input logic [15:0] a,
                            input logic [15:0] b, input logic [15:0] c);
    rd(p, OFF_DSI_PM_CAP, 32'(a[2]) << 21);
    rd(p, OFF_VGA_DECODE, 32'(c[7]) << 31);
    rd(p, OFF_PM_CTL_PARAM, {17'h0, c[6:0], 8'h0});
    rd(p, OFF_PHY_CTL5, {c[15:8], 24'h0});
    rd(p, OFF_EXP_CAP_SLOT, (p == 2'h0) ? 32'h0 : 32'(a[0]) << 24);
    rd(p, OFF_LOGICAL_PORT, {5'h0, a[6:4], 24'h0});
    rd(p, OFF_SLOT_CLOCK, 32'(a[1]) << 28);
    rd(p, OFF_LOW_PRIORITY_VC_COUNT, 32'(a[3]) << 4);
    rd(p, OFF_VC0_MAP, {24'h0, a[15:9], 1'b0});
    rd(p, OFF_BUDGET_DATA, {17'h0, b[11:10], 3'h0, b[9:0]});
    rd(p, OFF_BUDGET_ALLOC, {31'h0, b[15]});
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    present = 1'b1;
    go = 1'b0;
    cfg_rd = 1'b0;
    cfg_req = '0;
    do_reset();
    repeat (5) @(posedge clk);
    #1;
    go = 1'b1;
    rd(2'h2, OFF_VC0_MAP, {24'h0, opt_w[2][15:9], 1'b0});
    check({31'h0, done}, 32'h1);
    for (int p = 0; p < 3; p++)
      check_port(2'(p), opt_w[p], pb_w[p], pm_w[p]);
    rd(2'h1, OFF_VC0_MAP, {24'h0, opt_w[1][15:9], 1'b0});
    rd(2'h3, OFF_VC0_MAP, 32'h0);
    rd(2'h1, 12'h100, 32'h0);
    // enable low: request not taken, nothing moves
    @(posedge clk);
    #1;
    clk_en = 1'b0;
    cfg_rd = 1'b1;
    cfg_req = '{port: 2'h1, offset: OFF_VC0_MAP};
    @(posedge clk);
    #1;
    cfg_rd = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, ack}, 32'h0);
    check({31'h0, done}, 32'h1);
    clk_en = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, ack}, 32'h0);
    rd(2'h1, OFF_VC0_MAP, {24'h0, opt_w[1][15:9], 1'b0});
    $display("test clock enable done");
    $display("test load words done");
    go = 1'b0;
    present = 1'b0;
    do_reset();
    repeat (8) @(posedge clk);
    #1;
    check({31'h0, done}, 32'h1);
    for (int p = 0; p < 3; p++)
      check_port(2'(p), 16'h0, 16'h0, 16'h0);
    $display("test no storage done");
    stop_test();
  end

  initial begin
    #(100 * 5000);
    mismatches++;
    stop_test();
  end
endmodule
